/* File: design/minus_flags.sv */
// subtraction datapath with status flag evaluation
`timescale 1ns/1ps
module minus_flags
	import skip_sub_pkg::*;
(
	// operands
	input  wire logic [skip_sub_pkg::DATA_W-1:0] minuend,
	input  wire logic [skip_sub_pkg::DATA_W-1:0] subtrahend,
	// results
	output logic [skip_sub_pkg::DATA_W-1:0]      difference,
	output logic                                 no_borrow,
	output logic                                 nibble_no_borrow,
	output logic                                 signed_range,
	output logic                                 signed_sign,
	output logic                                 null_result
);
	wire logic [DATA_W:0] wide_diff;
	wire logic [NIBBLE_MSB+1:0] nib_diff;

	// extra bit holds the borrow out; result wraps modulo 256
	assign wide_diff = {1'b0, minuend} - {1'b0, subtrahend}; // [RULE_10]
	assign nib_diff = {1'b0, minuend[NIBBLE_MSB:0]} - {1'b0, subtrahend[NIBBLE_MSB:0]};
	assign difference = wide_diff[DATA_W-1:0];
	// set when the true difference is zero or positive
	assign no_borrow = ~wide_diff[DATA_W]; // [RULE_08]
	assign nibble_no_borrow = ~nib_diff[NIBBLE_MSB+1];
	assign signed_range = (minuend[SIGN_POS] != subtrahend[SIGN_POS]) &&
		(difference[SIGN_POS] != minuend[SIGN_POS]);
	// sign of the exact signed difference, correct even on overflow
	assign signed_sign = signed_range ^ difference[SIGN_POS];
	assign null_result = (difference == BYTE_ZERO);
endmodule

/* File: design/skip_and_subtract_exec.sv */
// execution unit for increment-skip, test-skip and subtract instructions
`timescale 1ns/1ps
// What this block does
// [RULE_01] increment memory byte, skip when sum zero
// [RULE_02] taken skip inserts dummy cycle, two cycles
// [RULE_03] increment into working register, memory untouched
// [RULE_04] skip when selected memory bit is one
// [RULE_05] rewrite byte, skip when byte nonzero
// [RULE_06] working register minus memory into register
// [RULE_07] working register minus memory into memory
// [RULE_08] borrow-not flag clear on negative difference
// [RULE_09] subtract updates flags, skips leave them
// [RULE_10] eight-bit modulo arithmetic, all-ones wraps zero
module skip_and_subtract_exec
	import skip_sub_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_DEF
) (
	// clock and reset
	input  wire logic                                mclk,
	input  wire logic                                reset,
	// instruction request from the sequencer
	input  wire logic                                op_valid,
	input  wire skip_sub_pkg::op_code_t              op_code,
	input  wire logic [ADDR_W-1:0]                   op_addr,
	input  wire logic [skip_sub_pkg::BIT_SEL_W-1:0]  op_bit,
	output logic                                     op_ready,
	// completion and skip toward the sequencer
	output logic                                     op_done,
	output logic                                     skip_next,
	output logic                                     dummy_cycle,
	// data memory port
	output logic                                     mem_rd_en,
	output logic                                     mem_wr_en,
	output logic [ADDR_W-1:0]                        mem_addr,
	output logic [skip_sub_pkg::DATA_W-1:0]          mem_wr_data,
	input  wire logic [skip_sub_pkg::DATA_W-1:0]     mem_rd_data,
	// working register and status flags
	output logic [skip_sub_pkg::DATA_W-1:0]          working_register,
	output logic                                     signed_range_flag,
	output logic                                     null_flag,
	output logic                                     nibble_borrow_flag,
	output logic                                     borrow_not_flag,
	output logic                                     signed_borrow_flag,
	output logic                                     chained_null_flag
);
	// ********************************
	// state and captured request
	// ********************************
	exec_state_t state_q;
	exec_state_t state_d;
	op_code_t op_q;
	logic [BIT_SEL_W-1:0] bit_q;
	logic [ADDR_W-1:0] addr_q;
	logic ready_q;
	logic done_q;
	logic skip_q;
	logic dummy_q;
	logic rd_en_q;
	logic wr_en_q;
	logic [DATA_W-1:0] wr_data_q;
	logic [DATA_W-1:0] wreg_q;
	logic ov_q;
	logic z_q;
	logic ac_q;
	logic c_q;
	logic sc_q;
	logic cz_q;

	// ********************************
	// datapath
	// ********************************
	wire logic [DATA_W-1:0] inc_sum;
	wire logic [DATA_W-1:0] sub_diff;
	wire logic sub_c;
	wire logic sub_ac;
	wire logic sub_ov;
	wire logic sub_sc;
	wire logic sub_z;
	wire logic take;
	wire logic in_exec;
	wire logic is_inc;
	wire logic is_sub;
	wire logic writes_mem;
	wire logic cond_inc;
	wire logic cond_bit;
	wire logic cond_byte;
	wire logic skip_cond;
	wire logic [DATA_W-1:0] wr_value;

	assign take = op_valid && ready_q && (state_q == ST_IDLE);
	assign in_exec = (state_q == ST_EXEC);
	assign inc_sum = mem_rd_data + BYTE_ONE; // [RULE_10]
	assign is_inc = (op_q == OP_INC_MEM) || (op_q == OP_INC_REG);
	assign is_sub = (op_q == OP_SUB_REG) || (op_q == OP_SUB_MEM);
	assign writes_mem = (op_q == OP_INC_MEM) || (op_q == OP_TEST_BYTE) || (op_q == OP_SUB_MEM);

	minus_flags u_minus (
		.minuend          (wreg_q),
		.subtrahend       (mem_rd_data),
		.difference       (sub_diff),
		.no_borrow        (sub_c),
		.nibble_no_borrow (sub_ac),
		.signed_range     (sub_ov),
		.signed_sign      (sub_sc),
		.null_result      (sub_z)
	);

	// skip conditions
	assign cond_inc = is_inc && (inc_sum == BYTE_ZERO); // [RULE_01] [RULE_03]
	assign cond_bit = (op_q == OP_TEST_BIT) && mem_rd_data[bit_q]; // [RULE_04]
	assign cond_byte = (op_q == OP_TEST_BYTE) && (mem_rd_data != BYTE_ZERO); // [RULE_05]
	assign skip_cond = cond_inc || cond_bit || cond_byte;

	// value written back: sum, same byte, or difference
	assign wr_value = (op_q == OP_INC_MEM) ? inc_sum : // [RULE_01]
		(op_q == OP_SUB_MEM) ? sub_diff : // [RULE_07]
		mem_rd_data; // [RULE_05]

	// ********************************
	// sequencer
	// ********************************
	// a skip parks in ST_SKIP so the slot of the next instruction becomes a dummy
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (take) begin
					state_d = ST_READ;
				end
			end
			ST_READ: state_d = ST_EXEC;
			ST_EXEC: state_d = skip_cond ? ST_SKIP : ST_IDLE; // [RULE_02]
			ST_SKIP: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			op_q <= OP_INC_MEM;
			bit_q <= '0;
			addr_q <= '0;
			ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (take) begin
				op_q <= op_code;
				bit_q <= op_bit;
				addr_q <= op_addr;
			end
			ready_q <= (state_d == ST_IDLE);
		end
	end

	// ********************************
	// memory strobes and event pulses
	// ********************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			rd_en_q <= 1'b0;
			wr_en_q <= 1'b0;
			wr_data_q <= BYTE_ZERO;
			done_q <= 1'b0;
			skip_q <= 1'b0;
			dummy_q <= 1'b0;
		end else begin
			rd_en_q <= take;
			wr_en_q <= in_exec && writes_mem; // [RULE_01] [RULE_05] [RULE_07]
			wr_data_q <= in_exec ? wr_value : wr_data_q;
			done_q <= in_exec;
			skip_q <= in_exec && skip_cond; // [RULE_02]
			dummy_q <= (state_d == ST_SKIP); // [RULE_02]
		end
	end

	// ********************************
	// working register and flags
	// ********************************
	// skip and test forms never reach the flag flops
	always_ff @(posedge mclk) begin
		if (reset) begin
			wreg_q <= WREG_RST;
			ov_q <= FLAG_RST;
			z_q <= FLAG_RST;
			ac_q <= FLAG_RST;
			c_q <= FLAG_RST;
			sc_q <= FLAG_RST;
			cz_q <= FLAG_RST;
		end else begin
			if (in_exec && (op_q == OP_INC_REG)) begin
				wreg_q <= inc_sum; // [RULE_03]
			end else if (in_exec && (op_q == OP_SUB_REG)) begin
				wreg_q <= sub_diff; // [RULE_06]
			end
			if (in_exec && is_sub) begin // [RULE_09]
				ov_q <= sub_ov;
				z_q <= sub_z;
				ac_q <= sub_ac;
				c_q <= sub_c; // [RULE_08]
				sc_q <= sub_sc;
				cz_q <= sub_z;
			end
		end
	end

	assign op_ready = ready_q;
	assign op_done = done_q;
	assign skip_next = skip_q;
	assign dummy_cycle = dummy_q;
	assign mem_rd_en = rd_en_q;
	assign mem_wr_en = wr_en_q;
	assign mem_addr = addr_q;
	assign mem_wr_data = wr_data_q;
	assign working_register = wreg_q;
	assign signed_range_flag = ov_q;
	assign null_flag = z_q;
	assign nibble_borrow_flag = ac_q;
	assign borrow_not_flag = c_q;
	assign signed_borrow_flag = sc_q;
	assign chained_null_flag = cz_q;
endmodule

/* File: design/skip_sub_pkg.sv */
// constants and types shared by the skip and subtract execution logic
package skip_sub_pkg;
	// ********************************
	// widths
	// ********************************
	localparam int DATA_W = 8;
	localparam int BIT_SEL_W = 3;
	localparam int ADDR_W_DEF = 8;
	localparam int NIBBLE_MSB = 3;
	localparam int SIGN_POS = 7;

	// ********************************
	// values after reset and byte constants
	// ********************************
	localparam logic [7:0] WREG_RST = 8'h00;
	localparam logic FLAG_RST = 1'b0;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ********************************
	// operation codes
	// ********************************
	typedef enum logic [2:0] {
		OP_INC_MEM  = 3'h0,
		OP_INC_REG  = 3'h1,
		OP_TEST_BIT = 3'h2,
		OP_TEST_BYTE = 3'h3,
		OP_SUB_REG  = 3'h4,
		OP_SUB_MEM  = 3'h5
	} op_code_t;

	// ********************************
	// sequencer states
	// ********************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_EXEC = 4'h4,
		ST_SKIP = 4'h8
	} exec_state_t;
endpackage

/* File: testbench/exec_mem_model.sv */
// data memory model with one-cycle read latency
`timescale 1ns/1ps
module exec_mem_model (
	input  wire logic       mclk,
	input  wire logic       mem_rd_en,
	input  wire logic       mem_wr_en,
	input  wire logic [7:0] mem_addr,
	input  wire logic [7:0] mem_wr_data,
	output logic      [7:0] mem_rd_data
);
	logic [7:0] mem [256];
	// outside the read slot the bus toggles, so stale data never passes as valid
	always @(posedge mclk) begin
		mem_rd_data <= mem_rd_en ? mem[mem_addr] : ~mem_rd_data;
		if (mem_wr_en) begin
			mem[mem_addr] <= mem_wr_data;
		end
	end
endmodule

/* File: testbench/skip_and_subtract_exec_tb_top.sv */
// self-checking bench for the skip and subtract execution unit
`timescale 1ns/1ps
module skip_and_subtract_exec_tb_top;
	import skip_sub_pkg::*;
	logic mclk, reset, op_valid, op_ready, op_done, skip_next, dummy_cycle, mem_rd_en, mem_wr_en;
	logic sr_f, z_f, ac_f, c_f, sc_f, cz_f, c_exp, z_exp, ov_exp, ac_exp, sc_exp;
	logic [15:0] got_v;
	logic [7:0] op_addr, mem_addr, mem_wr_data, mem_rd_data, working_register, w_exp;
	logic [7:0] sh [256];
	logic [2:0] op_bit;
	op_code_t op_code;
	logic [15:0] exp_q [$];
	logic [31:0] rs = 32'hFEB5B002;
	int error_cnt, check_count;
	skip_and_subtract_exec dut_u (.mclk, .reset, .op_valid, .op_code, .op_addr, .op_bit, .op_ready, .op_done,
		.skip_next, .dummy_cycle, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wr_data, .mem_rd_data,
		.working_register, .signed_range_flag(sr_f), .null_flag(z_f), .nibble_borrow_flag(ac_f),
		.borrow_not_flag(c_f), .signed_borrow_flag(sc_f), .chained_null_flag(cz_f));
	exec_mem_model mdl_u (.mclk, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wr_data, .mem_rd_data);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// every flag is watched, not only borrow and null
	assign got_v = {dummy_cycle, skip_next, working_register, sr_f, z_f, ac_f, c_f, sc_f, cz_f};
	task automatic chk_step(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t step got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_mem(input int i, input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t byte %0d got %h expected %h", $time, i, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// the note is queued at the take edge, in program order
	task automatic run(input op_code_t c, input logic [7:0] a, input logic [2:0] b);
		logic [7:0] m;
		logic [7:0] d;
		logic s;
		int n;
		int sd;
		m = sh[a];
		d = w_exp - m;
		sd = int'($signed(w_exp)) - int'($signed(m));
		s = 1'b0;
		n = 0;
		op_code <= c;
		op_addr <= a;
		op_bit <= b;
		op_valid <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (op_ready !== 1'b1 && n < 20);
		// a take that never comes is a failure of its own
		if (op_ready !== 1'b1) begin
			error_cnt++;
		end
		case (c)
			OP_INC_MEM: sh[a] = m + 8'h01;
			OP_INC_REG: w_exp = m + 8'h01;
			OP_TEST_BIT: s = m[b];
			OP_TEST_BYTE: s = m != 8'h00;
			default: begin
				c_exp = w_exp >= m;
				z_exp = d == 8'h00;
				ac_exp = w_exp[3:0] >= m[3:0];
				ov_exp = sd > 127 || sd < -128;
				sc_exp = sd < 0;
				if (c == OP_SUB_REG) w_exp = d;
				else sh[a] = d;
			end
		endcase
		if (c == OP_INC_MEM || c == OP_INC_REG) s = m == 8'hFF;
		// the dummy slot flag pulses together with the skip
		exp_q.push_back({s, s, w_exp, ov_exp, z_exp, ac_exp, c_exp, sc_exp, z_exp});
	endtask
	always @(posedge mclk) begin
		if (op_done === 1'b1) begin
			chk_step(got_v, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
		end
	end
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#50000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		reset = 1'b1;
		op_valid = 1'b0;
		op_code = OP_INC_MEM;
		op_addr = 8'h00;
		op_bit = 3'h0;
		w_exp = WREG_RST;
		c_exp = FLAG_RST;
		z_exp = FLAG_RST;
		ov_exp = FLAG_RST;
		ac_exp = FLAG_RST;
		sc_exp = FLAG_RST;
		for (int i = 0; i < 256; i++) begin
			rs = xs(rs);
			sh[i] = i < 2 ? 8'hFF : i == 2 ? 8'h00 : i == 3 ? 8'h80 : rs[7:0];
			mdl_u.mem[i] = sh[i];
		end
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		run(OP_INC_MEM, 8'h00, 3'h0);
		run(OP_INC_MEM, 8'h00, 3'h0);
		run(OP_INC_REG, 8'h01, 3'h0);
		run(OP_TEST_BYTE, 8'h02, 3'h0);
		run(OP_TEST_BYTE, 8'h03, 3'h0);
		run(OP_TEST_BIT, 8'h03, 3'h7);
		run(OP_TEST_BIT, 8'h03, 3'h6);
		run(OP_INC_REG, 8'h03, 3'h0);
		run(OP_SUB_REG, 8'h03, 3'h0);
		run(OP_SUB_MEM, 8'h02, 3'h0);
		run(OP_SUB_REG, 8'h00, 3'h0);
		run(OP_SUB_REG, 8'h03, 3'h0);
		for (int k = 0; k < 80; k++) begin
			rs = xs(rs);
			run(op_code_t'(3'(rs[2:0] % 3'd6)), rs[15:8] & 8'h0F, rs[18:16]);
		end
		op_valid <= 1'b0;
		repeat (8) @(posedge mclk);
		for (int i = 0; i < 256; i++) begin
			chk_mem(i, mdl_u.mem[i], sh[i]);
		end
		tally_and_finish();
	end
endmodule

/* File: testbench/skip_exec_props.sv */
// checker for the skip and subtract execution unit
`timescale 1ns/1ps
module skip_exec_props
	import skip_sub_pkg::*;
(
	input wire logic           mclk,
	input wire logic           reset,
	input wire logic           op_valid,
	input wire op_code_t       op_code,
	input wire logic [2:0]     op_bit,
	input wire logic           op_ready,
	input wire logic           op_done,
	input wire logic           skip_next,
	input wire logic           dummy_cycle,
	input wire logic           mem_rd_en,
	input wire logic           mem_wr_en,
	input wire logic [7:0]     mem_wr_data,
	input wire logic [7:0]     mem_rd_data,
	input wire logic [7:0]     working_register,
	input wire logic           borrow_not_flag,
	input wire logic           null_flag
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	logic       rp_q;
	logic [7:0] rd_q;
	logic [2:0] bit_q;
	op_code_t   op_q;
	wire  [7:0] inc = rd_q + 8'h01;
	wire        is_sub = op_q == OP_SUB_REG || op_q == OP_SUB_MEM;
	always_ff @(posedge mclk) begin
		rp_q <= mem_rd_en;
		if (rp_q) begin
			rd_q <= mem_rd_data;
		end
		if (op_valid && op_ready) begin
			op_q <= op_code;
			bit_q <= op_bit;
		end
	end
	take_to_done_a: assert property (
		op_valid && op_ready |=> mem_rd_en && !op_ready ##2 op_done)
		else $error("done not three cycles after take");
	// the dummy slot is flagged alongside the skip; the next take waits one extra cycle
	dummy_slot_a: assert property (
		skip_next |-> op_done && dummy_cycle && !op_ready ##1 op_ready && !dummy_cycle)
		else $error("skip without dummy slot");
	inc_mem_a: assert property (
		op_done && op_q == OP_INC_MEM |-> mem_wr_en && mem_wr_data == inc && skip_next == (inc == 8'h00))
		else $error("increment to memory wrong");
	inc_reg_a: assert property (
		op_done && op_q == OP_INC_REG |-> !mem_wr_en && working_register == inc && skip_next == (inc == 8'h00))
		else $error("increment to register wrong");
	bit_test_a: assert property (
		op_done && op_q == OP_TEST_BIT |-> !mem_wr_en && skip_next == rd_q[bit_q])
		else $error("bit test wrong");
	byte_test_a: assert property (
		op_done && op_q == OP_TEST_BYTE |-> mem_wr_en && mem_wr_data == rd_q && skip_next == (rd_q != 8'h00))
		else $error("byte test wrong");
	sub_reg_a: assert property (
		op_done && op_q == OP_SUB_REG |-> !skip_next && working_register == $past(working_register) - rd_q)
		else $error("subtract to register wrong");
	sub_mem_a: assert property (
		op_done && op_q == OP_SUB_MEM |->
		mem_wr_en && mem_wr_data == $past(working_register) - rd_q && $stable(working_register))
		else $error("subtract to memory wrong");
	borrow_flag_a: assert property (
		op_done && is_sub |-> borrow_not_flag == ($past(working_register) >= rd_q))
		else $error("borrow flag wrong");
	flag_hold_a: assert property (
		op_done && !is_sub |-> $stable(borrow_not_flag) && $stable(null_flag))
		else $error("flags moved on a skip op");
	cover property (skip_next);
	cover property (op_done && op_q == OP_SUB_MEM);
	cover property (dummy_cycle ##4 op_done);
endmodule
bind skip_and_subtract_exec skip_exec_props chk_u (.mclk, .reset, .op_valid, .op_code, .op_bit, .op_ready, .op_done,
	.skip_next, .dummy_cycle, .mem_rd_en, .mem_wr_en, .mem_wr_data, .mem_rd_data, .working_register,
	.borrow_not_flag, .null_flag);
